// ### common/tbr_pkg.sv
// timebase routing package: offsets, fields, reset values, counts
// assumes a 10 MHz mclk and a 32-bit classic wishbone slave port
package tbr_pkg;
  localparam int MCLK_HZ = 10000000;
  // backplane reference is judged absent after this long without an edge
  localparam int BP_ABSENT_NS = 2000;
  localparam int BP_ABSENT_CYC =
    (BP_ABSENT_NS * (MCLK_HZ / 1000000) + 999) / 1000;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] BP_ABSENT_CNT = CNT_W'(BP_ABSENT_CYC);

  localparam logic [3:0] ADR_CTRL = 4'h0;
  localparam logic [3:0] ADR_STAT = 4'h4;

  localparam int CTRL_DRIVE_BIT = 0;
  localparam int CTRL_LOCK_BIT = 1;
  localparam int CTRL_BPVAR_BIT = 2;

  localparam int STAT_PRESENT_BIT = 0;
  localparam int STAT_LOCKED_BIT = 1;
  localparam int STAT_DRIVING_BIT = 2;
  localparam int STAT_STAR_BIT = 3;
  localparam int STAT_SHARED_BIT = 4;

  typedef struct packed {
    logic bpVariant;
    logic lockEnable;
    logic driveBusClk;
  } tbr_ctrl_t;

  localparam tbr_ctrl_t CTRL_RESET = '{bpVariant: 1'b0,
    lockEnable: 1'b1, driveBusClk: 1'b0};

  typedef struct packed {
    logic sharedRef;
    logic starTrig;
    logic driving;
    logic lockActive;
    logic refPresent;
  } tbr_stat_t;

  // working timebase selection; only the crystal is ever selected
  typedef enum logic {TB_CRYSTAL, TB_SHARED} tbr_tbsel_t;

  localparam int SYNC_W = 4;
  localparam int SY_BP = 0;
  localparam int SY_MID = 1;
  localparam int SY_T7 = 2;
  localparam int SY_T6 = 3;
endpackage : tbr_pkg

// ### rtl/tbr_ref_detect.sv
// backplane reference presence detector
// assumes refLvl is already synchronised to mclk
`timescale 1ns/1ps
`default_nettype none
module tbr_ref_detect
  import tbr_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic refLvl,
  output logic present
);
  logic prev_q;
  logic present_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  wire refEdge = refLvl ^ prev_q;
  wire expired = (cnt_q == BP_ABSENT_CNT);

  // count saturates so a stopped clock keeps the flag low
  assign cnt_d = refEdge ? '0 : (expired ? cnt_q : cnt_q + 1'b1);

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      prev_q <= 1'b0;
      cnt_q <= BP_ABSENT_CNT;
      present_q <= 1'b0;
    end
    else
    begin
      prev_q <= refLvl;
      cnt_q <= cnt_d;
      present_q <= refEdge | (present_q & ~expired);
    end
  end
  assign present = present_q;

  a_edge_sets_present: assert property (@(posedge mclk)
    disable iff (!arst_n) refEdge |=> present_q)
    else $error("edge did not mark reference present");
  a_quiet_clears: assert property (@(posedge mclk)
    disable iff (!arst_n) expired && !refEdge |=> !present_q)
    else $error("quiet window did not clear present");
endmodule : tbr_ref_detect
`default_nettype wire

// ### rtl/tbr_timebase_route.sv
// timebase routing and bus clock control with wishbone registers
// assumes pins come from outside mclk and are synchronised here
// How it works
// - working timebase always from onboard crystal
// - drive mid-rate reference onto line 7
// - top-rate reference never reaches the bus
// - line 7 undriven after reset
// - backplane variant uses line 7 both ways
// - backplane variant locks top rate to reference
// - lock enabled at reset, software may clear
// - absent reference forces lock off
// - backplane variant treats line 6 as star
`timescale 1ns/1ps
`default_nettype none
module tbr_timebase_route
  import tbr_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic bpRefClk,
  input wire logic midRateRefClk,
  input wire logic trig7In,
  output logic trig7Out,
  output logic trig7Oe,
  input wire logic trig6In,
  output logic starTrig,
  output logic sharedRefClkIn,
  output logic pllRefClk,
  output logic pllLockEn,
  output logic workingTbSel
);
  logic [SYNC_W-1:0] syncA_q;
  logic [SYNC_W-1:0] syncB_q;
  tbr_ctrl_t ctrl_q;
  tbr_ctrl_t ctrl_d;
  tbr_stat_t stat;
  logic ack_q;
  logic [31:0] rdat_q;
  logic t7Out_q;
  logic t7Oe_q;
  logic star_q;
  logic shared_q;
  logic pllRef_q;
  logic lockEn_q;
  tbr_tbsel_t tbSel_q;
  logic refPresent;

  // two-flop synchronisers for every pin input
  wire [SYNC_W-1:0] pinsIn = {trig6In, trig7In, midRateRefClk, bpRefClk};

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      syncA_q <= '0;
      syncB_q <= '0;
    end
    else
    begin
      syncA_q <= pinsIn;
      syncB_q <= syncA_q;
    end
  end

  tbr_ref_detect u_detect (
    .mclk(mclk),
    .arst_n(arst_n),
    .refLvl(syncB_q[SY_BP]),
    .present(refPresent)
  );

  // wishbone decode
  wire wbReq = wb_cyc_i & wb_stb_i & ~ack_q;
  wire hitCtrl = (wb_adr_i == ADR_CTRL);
  wire hitStat = (wb_adr_i == ADR_STAT);
  wire wrCtrl = wbReq & wb_we_i & hitCtrl & wb_sel_i[0];

  always_comb
  begin
    ctrl_d = ctrl_q;
    if (wrCtrl)
    begin
      ctrl_d.driveBusClk = wb_dat_i[CTRL_DRIVE_BIT];
      ctrl_d.lockEnable = wb_dat_i[CTRL_LOCK_BIT];
      ctrl_d.bpVariant = wb_dat_i[CTRL_BPVAR_BIT];
    end
  end

  // one driver for the whole status word
  assign stat = '{sharedRef: shared_q, starTrig: star_q,
                  driving: t7Oe_q, lockActive: lockEn_q,
                  refPresent: refPresent};

  // unmapped offsets answer with zero data
  wire [31:0] rdSel = hitCtrl ? {29'h0, ctrl_q} :
                      hitStat ? {27'h0, stat} : 32'h0;

  // lock only in the backplane variant, with software and clock agreeing
  wire lockWant = ctrl_q.bpVariant & ctrl_q.lockEnable
                  & refPresent;

  // only the mid-rate reference is ever a source for the bus line
  wire t7Drive = ctrl_q.driveBusClk;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl_q <= CTRL_RESET;
      ack_q <= 1'b0;
      rdat_q <= 32'h0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      ack_q <= wbReq;
      rdat_q <= wbReq ? rdSel : 32'h0;
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      t7Oe_q <= 1'b0;
      t7Out_q <= 1'b0;
      lockEn_q <= 1'b0;
      pllRef_q <= 1'b0;
    end
    else
    begin
      t7Oe_q <= t7Drive;
      t7Out_q <= t7Drive & syncB_q[SY_MID];
      lockEn_q <= lockWant;
      pllRef_q <= ctrl_q.bpVariant & syncB_q[SY_BP];
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      star_q <= 1'b0;
      shared_q <= 1'b0;
      tbSel_q <= TB_CRYSTAL;
    end
    else
    begin
      star_q <= ctrl_q.bpVariant & syncB_q[SY_T6];
      // our own drive on line 7 is not taken as a shared reference
      shared_q <= ~t7Oe_q & syncB_q[SY_T7];
      tbSel_q <= TB_CRYSTAL;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign trig7Out = t7Out_q;
  assign trig7Oe = t7Oe_q;
  assign starTrig = star_q;
  assign sharedRefClkIn = shared_q;
  assign pllRefClk = pllRef_q;
  assign pllLockEn = lockEn_q;
  assign workingTbSel = tbSel_q;

  a_crystal_always: assert property (@(posedge mclk)
    disable iff (!arst_n) tbSel_q == TB_CRYSTAL)
    else $error("working timebase left the crystal");
  a_drive_follows: assert property (@(posedge mclk)
    disable iff (!arst_n)
    wrCtrl && wb_dat_i[CTRL_DRIVE_BIT] |=> ##1 trig7Oe)
    else $error("line 7 not driven after enable");
  a_mid_only: assert property (@(posedge mclk)
    disable iff (!arst_n)
    trig7Oe |-> trig7Out == $past(syncB_q[SY_MID]))
    else $error("line 7 carries something other than mid rate");
  a_quiet_out: assert property (@(posedge mclk)
    disable iff (!arst_n) !trig7Oe |-> !trig7Out)
    else $error("line 7 data toggles while undriven");
  a_no_self_rx: assert property (@(posedge mclk)
    disable iff (!arst_n) $past(t7Oe_q) |-> !sharedRefClkIn)
    else $error("own drive seen as shared reference");
  a_lock_needs_ref: assert property (@(posedge mclk)
    disable iff (!arst_n) pllLockEn |-> $past(refPresent))
    else $error("lock on without backplane reference");
  a_lock_sw_off: assert property (@(posedge mclk)
    disable iff (!arst_n)
    wrCtrl && !wb_dat_i[CTRL_LOCK_BIT] |=> ##1 !pllLockEn)
    else $error("lock stayed on after software clear");
  a_lock_on: assert property (@(posedge mclk)
    disable iff (!arst_n)
    ctrl_q.bpVariant && ctrl_q.lockEnable && refPresent
    |=> pllLockEn)
    else $error("lock off though all conditions hold");
  a_star_gated: assert property (@(posedge mclk)
    disable iff (!arst_n)
    !$past(ctrl_q.bpVariant) |-> !starTrig)
    else $error("star trigger active outside backplane variant");
  a_ack_single: assert property (@(posedge mclk)
    disable iff (!arst_n) wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  c_drive_on: cover property (@(posedge mclk)
    disable iff (!arst_n) $rose(trig7Oe));
  c_lock_on: cover property (@(posedge mclk)
    disable iff (!arst_n) $rose(pllLockEn));
  c_ref_lost: cover property (@(posedge mclk)
    disable iff (!arst_n) $fell(refPresent) && ctrl_q.lockEnable);
endmodule : tbr_timebase_route
`default_nettype wire

// ### verif/tbr_far_side.sv
// far side model: backplane reference clock and trigger lines 6 and 7
// assumes a 100 ns mclk; reference toggles every fourth edge (400 ns, 800 ns period)
`timescale 1ns/1ps
`default_nettype none
module tbr_far_side
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic bpRun,
  input wire logic line7,
  input wire logic line6,
  input wire logic trig7Out,
  input wire logic trig7Oe,
  output logic bpRefClk,
  output logic trig7In,
  output logic trig6In
);
  logic [1:0] phase_q;
  // no reference in the chassis: the clock stands still
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      phase_q <= 2'h0;
      bpRefClk <= 1'b0;
    end
    else if (bpRun)
    begin
      phase_q <= phase_q + 2'h1;
      if (phase_q == 2'h3)
        bpRefClk <= ~bpRefClk;
    end
  end
  // line 7 level: our board's driver wins while enabled
  assign trig7In = trig7Oe ? trig7Out : line7;
  assign trig6In = line6;
endmodule : tbr_far_side
`default_nettype wire

// ### verif/testbench.sv
// self-checking bench for the timebase routing block
// assumes tbr_far_side stands for the bus and backplane
`timescale 1ns/1ps
`default_nettype none
module testbench
  import tbr_pkg::*;
;
  logic mclk, arst_n, wbCyc, wbStb, wbWe, wbAck, midRate, bpRun;
  logic line7, line6, bpRefClk, trig7In, trig7Out, trig7Oe, trig6In;
  logic starTrig, sharedRef, pllRefClk, pllLockEn, workingTbSel;
  logic [3:0] wbAdr, wbSel;
  logic [31:0] wbDat, wbDatO, rd;
  logic [2:0] bpHist;
  int fails, check_count, cyc;

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  tbr_timebase_route uut (.mclk(mclk), .arst_n(arst_n), .wb_cyc_i(wbCyc),
    .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
    .wb_dat_i(wbDat), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
    .bpRefClk(bpRefClk), .midRateRefClk(midRate), .trig7In(trig7In),
    .trig7Out(trig7Out), .trig7Oe(trig7Oe), .trig6In(trig6In),
    .starTrig(starTrig), .sharedRefClkIn(sharedRef),
    .pllRefClk(pllRefClk), .pllLockEn(pllLockEn),
    .workingTbSel(workingTbSel));

  tbr_far_side far (.mclk(mclk), .arst_n(arst_n), .bpRun(bpRun),
    .line7(line7), .line6(line6), .trig7Out(trig7Out), .trig7Oe(trig7Oe),
    .bpRefClk(bpRefClk), .trig7In(trig7In), .trig6In(trig6In));

  task automatic conclude;
    $display("mismatches %0d comparisons %0d", fails, check_count);
    if (fails == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one classic cycle; read data lands in rd
  // waits for ack however long it takes; only the bench timeout ends it
  task automatic wb(input logic we, input logic [3:0] a,
    input logic [31:0] d);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbSel <= 4'hf;
    wbAdr <= a;
    wbDat <= d;
    do
    begin
      @(posedge mclk);
    end while (wbAck !== 1'b1);
    rd = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
    @(posedge mclk);
  endtask : wb

  // pins reach outputs three edges after they change
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
  endtask : settle

  // reference level as the block should pass it on, three edges later
  always @(posedge mclk)
  begin
    bpHist <= {bpHist[1:0], bpRefClk};
  end

  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fails++;
      conclude();
    end
  end

  initial
  begin
    arst_n = 1'b0;
    {wbCyc, wbStb, wbWe, midRate, bpRun, line7, line6} = 7'h00;
    wbAdr = 4'h0;
    wbSel = 4'hf;
    wbDat = 32'h0;
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    chk(trig7Oe, 1'b0);
    chk(workingTbSel, 1'b0);
    wb(1'b0, ADR_CTRL, 32'h0);
    chk(rd, 32'h2);
    wb(1'b0, 4'h8, 32'h0);
    chk(rd, 32'h0);
    line7 <= 1'b1;
    settle(4);
    chk(sharedRef, 1'b1);
    midRate <= 1'b1;
    wb(1'b1, ADR_CTRL, 32'h3);
    settle(4);
    chk(trig7Oe, 1'b1);
    chk(trig7Out, 1'b1);
    chk(sharedRef, 1'b0);
    midRate <= 1'b0;
    settle(4);
    chk(trig7Out, 1'b0);
    line7 <= 1'b0;
    bpRun <= 1'b1;
    wb(1'b1, ADR_CTRL, 32'h6);
    settle(12);
    chk(pllLockEn, 1'b1);
    chk(pllRefClk, bpHist[2]);
    wb(1'b0, ADR_STAT, 32'h0);
    chk(rd, 32'h3);
    line6 <= 1'b1;
    settle(4);
    chk(starTrig, 1'b1);
    wb(1'b1, ADR_CTRL, 32'h4);
    settle(3);
    chk(pllLockEn, 1'b0);
    wb(1'b1, ADR_CTRL, 32'h6);
    settle(3);
    chk(pllLockEn, 1'b1);
    chk(pllRefClk, bpHist[2]);
    bpRun <= 1'b0;
    settle(30);
    chk(pllLockEn, 1'b0);
    wb(1'b0, ADR_STAT, 32'h0);
    chk(rd, 32'h8);
    wb(1'b1, ADR_CTRL, 32'h0);
    settle(4);
    chk(starTrig, 1'b0);
    conclude();
  end
endmodule : testbench
`default_nettype wire
